/* route_feedback_regs.svh */
/*
 * constants for the route feedback reporter: ascii codes, field counts
 * assumes nothing; definitions only
 */
`ifndef ROUTE_FEEDBACK_REGS_SVH
`define ROUTE_FEEDBACK_REGS_SVH

`define CH_I       8'h49
`define CH_O       8'h4f
`define CH_A       8'h41
`define CH_V       8'h56
`define CH_S       8'h53
`define CH_CR      8'h0d
`define CH_ZERO    8'h30
`define MAX_INPUT  3'h4
`define OUT_FIRST  2'h1
`define OUT_LAST   2'h2
`define ROUTE_LEN  4'h7   // index of the last route reply byte
`define SCHEMA_LEN 4'h9   // index of the last schema reply byte
`define ROUTE_RST  3'h0

`endif

/* route_feedback_pkg.sv */
/*
 * types for the route feedback reporter
 * assumes route_feedback_regs.svh is included by users of the constants
 */
package route_feedback_pkg;

  // the four routes: output one audio, one video, two audio, two video
  typedef struct packed {
    logic [2:0] a1;
    logic [2:0] v1;
    logic [2:0] a2;
    logic [2:0] v2;
  } schema_t;

  // one switch request from the command parser
  typedef struct packed {
    logic       set_audio;
    logic       set_video;
    logic [1:0] output_sel;
    logic [2:0] input_sel;
  } switch_req_t;

  // query request from the command parser
  typedef struct packed {
    logic       query_all;
    logic       query_audio;
    logic       query_video;
    logic [1:0] output_sel;
  } query_req_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_ROUTE  = 4'b0010,
    ST_SCHEMA = 4'b0100,
    ST_PEND   = 4'b1000
  } send_state_t;

endpackage

/* route_feedback_reporter.sv */
/*
 * route_feedback_reporter: holds the 4x2 audio/video route table and sends
 * ascii feedback strings one byte per handshake on the feedback output.
 * assumes the command parser gives one-cycle request pulses, only while
 * busy is low, and that the serial transmitter takes bytes on valid&ready.
 */
//
// Overview of operation
// - changed audio route sends I, input digits, O, output digits, A, CR
// - changed video route sends the same with V, output 01 to 02
// - schema reply: S, then a1 v1 a2 v2, then CR
// - every number goes out as two decimal digits, leading zero
// - no reply for an output whose route did not change
// - no serial replies for switches made in local front-panel mode
// - unsolicited change replies only with verbose on and system mode
// - queries are answered whatever the verbose setting
// - input zero means no source, one to four the inputs
`timescale 1ns/1ns
`default_nettype none
`include "route_feedback_regs.svh"

module route_feedback_reporter
  import route_feedback_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // mode inputs
  input  wire logic        verbose_on,
  input  wire logic        local_mode,
  // requests from the command parser
  input  wire switch_req_t switch_req,
  input  wire logic        switch_valid,
  input  wire query_req_t  query_req,
  input  wire logic        query_valid,
  // byte stream to the serial transmitter
  output var  logic [7:0]  feedback_string_out,
  output var  logic        feedback_valid,
  input  wire logic        feedback_ready,
  // status
  output var  logic        busy,
  output var  logic        local_mode_indicator,
  output var  schema_t     routes
);

  ////////////////////////////////////////////////////////////////////////
  // state
  schema_t     routes_reg,  routes_next;
  send_state_t state_reg,   state_next;
  logic [3:0]  idx_reg,     idx_next;
  logic        kind_v_reg,  kind_v_next;   // route reply is video
  logic [1:0]  out_reg,     out_next;
  logic [2:0]  in_reg,      in_next;
  logic        pend_reg,    pend_next;     // video reply still owed
  logic [2:0]  pend_in_reg, pend_in_next;
  logic [7:0]  byte_reg,    byte_next;
  logic        valid_reg,   valid_next;
  logic        busy_reg,    busy_next;     // reply in progress
  logic        local_reg;

  // ascii digit of a route value, one character; the leading zero is sent separately
  function automatic logic [7:0] digit(input logic [2:0] v);
    digit = `CH_ZERO + {5'h00, v};
  endfunction

  // current route of one output
  function automatic logic [2:0] cur_route(input schema_t s, input logic v, input logic [1:0] o);
    if (o == `OUT_FIRST) begin
      cur_route = v ? s.v1 : s.a1;
    end else begin
      cur_route = v ? s.v2 : s.a2;
    end
  endfunction

  // character of a route reply at one position
  function automatic logic [7:0] route_char(input logic [3:0] i, input logic v,
                                             input logic [2:0] x, input logic [1:0] o);
    case (i)
      4'h0:    route_char = `CH_I;
      4'h1:    route_char = `CH_ZERO;
      4'h2:    route_char = digit(x);
      4'h3:    route_char = `CH_O;
      4'h4:    route_char = `CH_ZERO;
      4'h5:    route_char = digit({1'b0, o});
      4'h6:    route_char = v ? `CH_V : `CH_A;
      default: route_char = `CH_CR;
    endcase
  endfunction

  // character of the schema reply at one position
  function automatic logic [7:0] schema_char(input logic [3:0] i, input schema_t s);
    case (i)
      4'h0:    schema_char = `CH_S;
      4'h1:    schema_char = `CH_ZERO;
      4'h2:    schema_char = digit(s.a1);
      4'h3:    schema_char = `CH_ZERO;
      4'h4:    schema_char = digit(s.v1);
      4'h5:    schema_char = `CH_ZERO;
      4'h6:    schema_char = digit(s.a2);
      4'h7:    schema_char = `CH_ZERO;
      4'h8:    schema_char = digit(s.v2);
      default: schema_char = `CH_CR;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic       ok;
    logic       chg_a;
    logic       chg_v;
    logic       tell;
    logic [3:0] len;
    logic [3:0] nidx;
    ok    = 1'b0;
    chg_a = 1'b0;
    chg_v = 1'b0;
    tell  = 1'b0;
    len   = `ROUTE_LEN;
    nidx  = 4'h0;
    routes_next  = routes_reg;
    state_next   = state_reg;
    idx_next     = idx_reg;
    kind_v_next  = kind_v_reg;
    out_next     = out_reg;
    in_next      = in_reg;
    pend_next    = pend_reg;
    pend_in_next = pend_in_reg;
    byte_next    = byte_reg;
    valid_next   = valid_reg;
    case (state_reg)
      ST_IDLE: begin
        if (switch_valid) begin
          // input range: bad input or output is ignored
          ok = (switch_req.input_sel <= `MAX_INPUT) &&
               (switch_req.output_sel >= `OUT_FIRST) && (switch_req.output_sel <= `OUT_LAST);
          chg_a = ok && switch_req.set_audio &&
                  (cur_route(routes_reg, 1'b0, switch_req.output_sel) != switch_req.input_sel);
          chg_v = ok && switch_req.set_video &&
                  (cur_route(routes_reg, 1'b1, switch_req.output_sel) != switch_req.input_sel);
          if (chg_a && switch_req.output_sel == `OUT_FIRST) routes_next.a1 = switch_req.input_sel;
          if (chg_a && switch_req.output_sel == `OUT_LAST)  routes_next.a2 = switch_req.input_sel;
          if (chg_v && switch_req.output_sel == `OUT_FIRST) routes_next.v1 = switch_req.input_sel;
          if (chg_v && switch_req.output_sel == `OUT_LAST)  routes_next.v2 = switch_req.input_sel;
          // silent unless verbose in system mode
          tell = verbose_on && !local_reg;
          out_next = switch_req.output_sel;
          in_next  = switch_req.input_sel;
          if (tell && (chg_a || chg_v)) begin
            kind_v_next  = !chg_a;
            pend_next    = chg_a && chg_v;
            pend_in_next = switch_req.input_sel;
            idx_next     = 4'h0;
            byte_next    = route_char(4'h0, !chg_a, switch_req.input_sel, switch_req.output_sel);
            valid_next   = 1'b1;
            state_next   = ST_ROUTE;
          end
        end else if (query_valid) begin
          if (query_req.query_all) begin
            idx_next   = 4'h0;
            byte_next  = `CH_S;
            valid_next = 1'b1;
            state_next = ST_SCHEMA;
          end else if ((query_req.query_audio || query_req.query_video) &&
                       (query_req.output_sel >= `OUT_FIRST) && (query_req.output_sel <= `OUT_LAST)) begin
            kind_v_next = query_req.query_video;
            out_next    = query_req.output_sel;
            in_next     = cur_route(routes_reg, query_req.query_video, query_req.output_sel);
            pend_next   = 1'b0;
            idx_next    = 4'h0;
            byte_next   = `CH_I;
            valid_next  = 1'b1;
            state_next  = ST_ROUTE;
          end
        end
      end
      ST_ROUTE, ST_SCHEMA: begin
        len = (state_reg == ST_SCHEMA) ? `SCHEMA_LEN : `ROUTE_LEN;
        if (feedback_ready) begin
          nidx = idx_reg + 4'h1;
          if (nidx > len) begin
            valid_next = 1'b0;
            state_next = pend_reg ? ST_PEND : ST_IDLE;
          end else begin
            idx_next = nidx;
            byte_next = (state_reg == ST_SCHEMA) ? schema_char(nidx, routes_reg)
                                                 : route_char(nidx, kind_v_reg, in_reg, out_reg);
          end
        end
      end
      ST_PEND: begin
        kind_v_next = 1'b1;
        in_next     = pend_in_reg;
        pend_next   = 1'b0;
        idx_next    = 4'h0;
        byte_next   = `CH_I;
        valid_next  = 1'b1;
        state_next  = ST_ROUTE;
      end
      default: begin
        state_next = ST_IDLE;
        valid_next = 1'b0;
      end
    endcase
    // busy follows the next state so it can stand in a flip-flop
    busy_next = (state_next != ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      routes_reg  <= '{`ROUTE_RST, `ROUTE_RST, `ROUTE_RST, `ROUTE_RST};
      state_reg   <= ST_IDLE;
      idx_reg     <= 4'h0;
      kind_v_reg  <= 1'b0;
      out_reg     <= 2'h0;
      in_reg      <= 3'h0;
      pend_reg    <= 1'b0;
      pend_in_reg <= 3'h0;
      byte_reg    <= 8'h00;
      valid_reg   <= 1'b0;
      busy_reg    <= 1'b0;
      local_reg   <= 1'b0;
    end else begin
      routes_reg  <= routes_next;
      state_reg   <= state_next;
      idx_reg     <= idx_next;
      kind_v_reg  <= kind_v_next;
      out_reg     <= out_next;
      in_reg      <= in_next;
      pend_reg    <= pend_next;
      pend_in_reg <= pend_in_next;
      byte_reg    <= byte_next;
      valid_reg   <= valid_next;
      busy_reg    <= busy_next;
      local_reg   <= local_mode;   // same-domain mode level
    end
  end

  // outputs straight from flip-flops
  assign feedback_string_out  = byte_reg;
  assign feedback_valid       = valid_reg;
  assign busy                 = busy_reg;
  assign local_mode_indicator = local_reg;
  assign routes               = routes_reg;

endmodule
`default_nettype wire

/* rfr_properties.sv */
/* reply timing checks for the route feedback reporter
   sees only the top module ports; bound at the foot */
`timescale 1ns/1ns
`default_nettype none
`include "route_feedback_regs.svh"
module rfr_properties
  import route_feedback_pkg::*;
(
  // clock, reset, modes
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        verbose_on,
  input wire logic        local_mode,
  // requests
  input wire switch_req_t switch_req,
  input wire logic        switch_valid,
  input wire query_req_t  query_req,
  input wire logic        query_valid,
  // reporter outputs and feedback_ready
  input wire logic [7:0]  feedback_string_out,
  input wire logic        feedback_valid,
  input wire logic        feedback_ready,
  input wire logic        busy,
  input wire logic        local_mode_indicator,
  input wire schema_t     routes
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic take;
  // accepted switch request
  assign take = switch_valid && !busy;
  property p_hold; feedback_valid && !feedback_ready |=> feedback_valid && $stable(feedback_string_out); endproperty
  a_hold: assert property (p_hold) else $error("byte lost");
  property p_lmi; $past(rstn) |-> local_mode_indicator == $past(local_mode); endproperty
  a_lmi: assert property (p_lmi) else $error("indicator wrong");
  property p_start; $rose(feedback_valid) |-> feedback_string_out inside {`CH_I, `CH_S}; endproperty
  a_start: assert property (p_start) else $error("bad first byte");
  property p_pad;
    feedback_valid && feedback_ready && feedback_string_out == `CH_I |->
      ##[1:2] feedback_valid && feedback_string_out == `CH_ZERO;
  endproperty
  a_pad: assert property (p_pad) else $error("no leading zero");
  property p_local; take && local_mode_indicator |=> !feedback_valid [*2]; endproperty
  a_local: assert property (p_local) else $error("reply in local mode");
  property p_quiet; take && !verbose_on |=> !feedback_valid [*2]; endproperty
  a_quiet: assert property (p_quiet) else $error("reply with verbose off");
  property p_query;
    query_valid && !switch_valid && !busy && query_req.query_all |=> feedback_valid && feedback_string_out == `CH_S;
  endproperty
  a_query: assert property (p_query) else $error("query unanswered");
  property p_table;
    take && switch_req.set_audio && switch_req.output_sel == `OUT_FIRST && switch_req.input_sel <= `MAX_INPUT
      |=> routes.a1 == $past(switch_req.input_sel);
  endproperty
  a_table: assert property (p_table) else $error("table not updated");
  property p_same;
    take && switch_req.set_video && !switch_req.set_audio && switch_req.output_sel == `OUT_LAST
      && switch_req.input_sel == routes.v2 |=> !feedback_valid [*2];
  endproperty
  a_same: assert property (p_same) else $error("reply for no change");
  c_local: cover property (take && local_mode_indicator);
  c_query: cover property (query_valid && query_req.query_all);
  c_stall: cover property (feedback_valid && !feedback_ready);
endmodule
bind route_feedback_reporter rfr_properties i_rfr_properties (
  .clk                  (clk),
  .rstn                 (rstn),
  .verbose_on           (verbose_on),
  .local_mode           (local_mode),
  .switch_req           (switch_req),
  .switch_valid         (switch_valid),
  .query_req            (query_req),
  .query_valid          (query_valid),
  .feedback_string_out  (feedback_string_out),
  .feedback_valid       (feedback_valid),
  .feedback_ready       (feedback_ready),
  .busy                 (busy),
  .local_mode_indicator (local_mode_indicator),
  .routes               (routes)
);
`default_nettype wire

/* rfr_rx_model.sv */
/* serial transmitter side: takes reply bytes into a queue
   assumes one clock domain with the reporter */
`timescale 1ns/1ns
`default_nettype none
module rfr_rx_model (
  // clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // pacing
  input wire logic       slow,
  // byte stream
  input wire logic       feedback_valid,
  input wire logic [7:0] feedback_string_out,
  output var logic       feedback_ready
);
  logic [7:0] got[$];
  // take bytes, stall every other cycle when slow
  always @(posedge clk or negedge rstn) begin
    if (!rstn) feedback_ready <= 1'b0;
    else begin
      if (feedback_valid && feedback_ready) got.push_back(feedback_string_out);
      feedback_ready <= slow ? !feedback_ready : 1'b1;
    end
  end
endmodule
`default_nettype wire

/* tb_route_feedback_reporter.sv */
/* self-checking bench for the route feedback reporter
   assumes rfr_rx_model as the byte taker */
`timescale 1ns/1ns
`default_nettype none
module tb_route_feedback_reporter
  import route_feedback_pkg::*;
;
  logic        clk = 1'b0, rstn = 1'b0, verbose_on = 1'b1, local_mode = 1'b0, slow = 1'b0;
  logic        switch_valid = 1'b0, query_valid = 1'b0, feedback_valid, feedback_ready, busy;
  logic        local_mode_indicator;
  logic [7:0]  feedback_string_out;
  switch_req_t switch_req = '0;
  query_req_t  query_req = '0;
  schema_t     routes;
  int          fail_count = 0, checks = 0;
  always #25 clk = ~clk;
  route_feedback_reporter i_route_feedback_reporter (
    .clk                  (clk),
    .rstn                 (rstn),
    .verbose_on           (verbose_on),
    .local_mode           (local_mode),
    .switch_req           (switch_req),
    .switch_valid         (switch_valid),
    .query_req            (query_req),
    .query_valid          (query_valid),
    .feedback_string_out  (feedback_string_out),
    .feedback_valid       (feedback_valid),
    .feedback_ready       (feedback_ready),
    .busy                 (busy),
    .local_mode_indicator (local_mode_indicator),
    .routes               (routes)
  );
  rfr_rx_model i_rfr_rx_model (
    .clk                  (clk),
    .rstn                 (rstn),
    .slow                 (slow),
    .feedback_valid       (feedback_valid),
    .feedback_string_out  (feedback_string_out),
    .feedback_ready       (feedback_ready)
  );
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic string rr(int i, int o, string k);
    return $sformatf("I%02dO%02d%s\015", i, o, k);
  endfunction
  // wait for the reply to finish, then compare bytes
  task automatic reply(string s);
    repeat (3) @(posedge clk);
    for (int n = 0; n < 400 && (busy || i_rfr_rx_model.got.size() < s.len()); n++) @(posedge clk);
    chk(i_rfr_rx_model.got.size(), s.len());
    for (int k = 0; k < s.len() && k < i_rfr_rx_model.got.size(); k++) chk(i_rfr_rx_model.got[k], s[k]);
    i_rfr_rx_model.got.delete();
  endtask
  task automatic sw(logic a, logic v, logic [1:0] o, logic [2:0] i, string s);
    @(posedge clk);
    switch_req <= '{a, v, o, i};
    switch_valid <= 1'b1;
    @(posedge clk);
    switch_valid <= 1'b0;
    reply(s);
  endtask
  task automatic qry(logic al, logic au, logic vi, logic [1:0] o, string s);
    @(posedge clk);
    query_req <= '{al, au, vi, o};
    query_valid <= 1'b1;
    @(posedge clk);
    query_valid <= 1'b0;
    reply(s);
  endtask
  task automatic t_both();
    slow <= 1'b1;
    sw(1, 1, 2'h2, 3'h4, {rr(4, 2, "A"), rr(4, 2, "V")});
    slow <= 1'b0;
  endtask
  task automatic t_unchanged();
    sw(0, 1, 2'h2, 3'h4, "");
    sw(1, 1, 2'h1, 3'h3, rr(3, 1, "V"));
    sw(1, 0, 2'h1, 3'h5, "");
    chk(routes, schema_t'{3'h3, 3'h3, 3'h4, 3'h4});
  endtask
  task automatic t_local();
    local_mode <= 1'b1;
    sw(1, 0, 2'h1, 3'h0, "");
    chk(routes.a1, 3'h0);
    local_mode <= 1'b0;
    repeat (2) @(posedge clk);
    chk(local_mode_indicator, 1'b0);
    qry(1, 0, 0, 2'h0, "S00030404\015");
  endtask
  task automatic t_quiet();
    verbose_on <= 1'b0;
    sw(0, 1, 2'h2, 3'h1, "");
    qry(0, 1, 0, 2'h2, rr(4, 2, "A"));
    qry(0, 0, 1, 2'h2, rr(1, 2, "V"));
  endtask
  // first audio switch from an empty table
  task automatic t_first();
    chk(routes, 16'h0);
    sw(1, 0, 2'h1, 3'h3, rr(3, 1, "A"));
  endtask
  // mid-run reset clears the table, then a schema query
  task automatic t_reset();
    rstn <= 1'b0;
    @(posedge clk);
    chk(routes, 16'h0);
    chk(feedback_valid, 1'b0);
    rstn <= 1'b1;
    qry(1, 0, 0, 2'h0, "S00000000\015");
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_first();
    t_both();
    t_unchanged();
    t_local();
    t_quiet();
    t_reset();
    close_out();
  end
  // watchdog
  initial begin
    #1000000;
    fail_count++;
    close_out();
  end
endmodule
`default_nettype wire
